// *** verilog/spi_slave_cfg.svh ***
// Register indices, field positions and reset values of the SPI slave
`ifndef SPI_SLAVE_CFG_SVH
`define SPI_SLAVE_CFG_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define IDX_SLAVE_CONFIG      16'hFC60
`define IDX_TX_POINTER        16'hFC61
`define IDX_RX_LENGTH         16'hFC62
`define IDX_RX_POINTER        16'hFC63
`define IDX_RING_CONFIG       16'hFC64
`define IDX_RX_CURRENT        16'hFC65
`define IDX_EVENT_STATUS      16'hFC66

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CFG_FAST_SYNC         15
`define CFG_RX_MSB            14
`define CFG_TX_MSB            13
`define TXP_TX_EN             15
`define TXP_RX_EN             14
`define TXP_BUSY              13
`define LEN_PIN_ROUTE         15
`define LEN_TX_EDGE           14
`define RXP_BUSY              13
`define RXP_AUTO              12
`define RB_TX_EN              7
`define RB_TX_SZ              4
`define RB_RX_EN              3
`define RB_RX_SZ              0
`define EV_ENABLE             14
`define EV_TX_HALF2           13
`define EV_TX_HALF1           12
`define EV_RX_HALF2           11
`define EV_RX_HALF1           10
`define EV_ABORT              9
`define EV_STOP               3
`define EV_START              2

// ----------------------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------------------
`define REG_RESET             16'h0000
`define EV_W1C_MASK           16'h3C0C
`define RING_LOCK_BASE        11'h7C0
`define SYNC_RESET            4'hF

`endif

// *** verilog/spi_slave_pkg.sv ***
// Types shared by the SPI slave ring buffer design
package spi_slave_pkg;

   typedef enum logic [3:0] {
      TX_IDLE  = 4'b0001,
      TX_LOAD  = 4'b0010,
      TX_FETCH = 4'b0100,
      TX_RUN   = 4'b1000
   } tx_state_t;

   typedef struct packed {
      logic [3:0]  sck_sync;
      logic [3:0]  cs_sync;
      logic [3:0]  mosi_sync;
      logic [15:0] cfg;
      logic [15:0] txptr;
      logic [15:0] rxlen;
      logic [15:0] rxptr;
      logic [15:0] rbuf;
      logic [15:0] evt;
      logic        rx_busy;
      logic [10:0] rx_addr;
      logic [9:0]  rx_count;
      logic [7:0]  rx_shift;
      logic [2:0]  rx_bits;
      logic        rx_half;
      logic [7:0]  rx_hi;
      tx_state_t   tx_state;
      logic [10:0] tx_addr;
      logic [15:0] tx_word;
      logic        tx_lo;
      logic [2:0]  tx_bits;
      logic        miso;
      logic        miso_oe;
      logic        mem_rd;
      logic        mem_wr;
      logic [10:0] mem_wr_addr;
      logic [15:0] mem_wr_data;
      logic [31:0] prdata;
   } slave_state_t;

endpackage

// *** verilog/spi_slave_ring_buffer.sv ***
// SPI slave moving bytes between an external master and peripheral word memory
//
// How it works
// R1: Length register bit 15 hands the four shared pins to this slave.
// R2: Config bit 15 shortens input synchronisation for same-clock setups.
// R3: Bit 14 sets receive, bit 13 transmit order; set means MSB first.
// R4: Transmit and receive enables gate data; start/stop events always occur.
// R5: Transmitter busy reads one while transmit enabled and chip select low.
// R6: Transmit data is fetched from the word address in pointer bits 8:0.
// R7: Length bit 14 picks transmit edge: clear falling, set rising.
// R8: Rising-edge transmit is advised above one sixth of core clock.
// R9: Master keeps SPI clock at or below a quarter of core clock.
// R10: At packet end the received byte count loads length bits 9:0.
// R11: Receiver busy bit sets when the receiver goes idle to busy.
// R12: Auto-enable bit makes transmit completion enable the receiver.
// R13: Going busy copies receive start address into the write pointer.
// R14: Read-only current address shows where received data is stored.
// R15: Ring register holds receive enable bit 3 and size bits 2:0.
// R16: Size codes give 64..512 words; upper address bits stay, lower wrap.
// R17: Start event on chip select falling, stop event on rising.
// R18: Ring pointers reaching middle or end of buffer raise events.
// R19: Software loads pointers before setting the matching enable.
// R20: Event request goes out only with the event enable set.
// R21: Abort flag clears at start, sets if stop comes mid-byte.
// R22: Writing one clears an event flag other than abort, writing zero leaves it.
// R23: Received words stored at incrementing pointer; transmit reads consecutive words.
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_cfg.svh"

module spi_slave_ring_buffer
   import spi_slave_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        spi_clk,
   input  wire logic        chip_select_n,
   input  wire logic        spi_mosi,
   output var  logic        spi_miso_out,
   output var  logic        spi_miso_oe,
   output var  logic        pin_route_select,
   output var  logic        event_request,
   output var  logic        mem_rd_en,
   output var  logic [10:0] mem_rd_addr,
   input  wire logic [15:0] mem_rd_data,
   output var  logic        mem_wr_en,
   output var  logic [10:0] mem_wr_addr,
   output var  logic [15:0] mem_wr_data
);

   // -------------------------------------------------------------------------
   // Decode helpers
   // -------------------------------------------------------------------------
   function automatic logic [2:0] reg_sel(input logic [31:0] a);
      logic [2:0] s;
      s = 3'd7;
      if (a[1:0] == 2'b00 && a[31:18] == 14'h0000) begin
         case (a[17:2])
            `IDX_SLAVE_CONFIG: s = 3'd0;
            `IDX_TX_POINTER:   s = 3'd1;
            `IDX_RX_LENGTH:    s = 3'd2;
            `IDX_RX_POINTER:   s = 3'd3;
            `IDX_RING_CONFIG:  s = 3'd4;
            `IDX_RX_CURRENT:   s = 3'd5;
            `IDX_EVENT_STATUS: s = 3'd6;
            default:           s = 3'd7;
         endcase
      end
      return s;
   endfunction

   // Codes above 011 fold onto the low two bits
   function automatic logic [10:0] ring_mask(input logic [2:0] sz);
      return ~(`RING_LOCK_BASE << sz[1:0]);
   endfunction

   function automatic logic [10:0] ring_next(input logic [10:0] a, input logic en, input logic [2:0] sz);
      logic [10:0] m;
      m = ring_mask(sz);
      if (en) begin
         return (a & ~m) | ((a + 11'd1) & m); // [R16]
      end
      return a + 11'd1;
   endfunction

   // {end, middle} of the ring for a freshly advanced pointer
   function automatic logic [1:0] ring_mark(input logic [10:0] a, input logic [2:0] sz);
      logic [10:0] m;
      m = ring_mask(sz);
      return {(a & m) == 11'd0, (a & m) == ((m >> 1) + 11'd1)};
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   slave_state_t st_ff;
   slave_state_t nxt_st;

   logic        fast;
   logic        route;
   logic        cs_low;
   logic        cs_low_prev;
   logic        cs_fall;
   logic        cs_rise;
   logic        sck_rise;
   logic        sck_fall;
   logic        mosi_bit;
   logic        shift_edge;
   logic        wr_acc;
   logic [2:0]  sel;
   logic [7:0]  rx_byte;
   logic [7:0]  tx_byte;
   logic [10:0] adv;
   logic [1:0]  mark;
   logic        tx_busy;
   logic        ring_tx_en;
   logic        ring_rx_en;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.mem_rd = 1'b0;
      nxt_st.mem_wr = 1'b0;
      adv = 11'd0;
      mark = 2'b00;
      rx_byte = 8'h00;

      // Stage 0 feeds only stage 1; edges come from later stages
      nxt_st.sck_sync  = {st_ff.sck_sync[2:0], spi_clk};
      nxt_st.cs_sync   = {st_ff.cs_sync[2:0], chip_select_n};
      nxt_st.mosi_sync = {st_ff.mosi_sync[2:0], spi_mosi};

      // Fast mode drops one stage of latency; only safe with a shared clock
      fast = st_ff.cfg[`CFG_FAST_SYNC]; // [R2]
      route = st_ff.rxlen[`LEN_PIN_ROUTE]; // [R1]
      cs_low = route & ~(fast ? st_ff.cs_sync[1] : st_ff.cs_sync[2]);
      cs_low_prev = route & ~(fast ? st_ff.cs_sync[2] : st_ff.cs_sync[3]);
      cs_fall = cs_low & ~cs_low_prev;
      cs_rise = ~cs_low & cs_low_prev;
      sck_rise = cs_low & (fast ? (st_ff.sck_sync[1] & ~st_ff.sck_sync[2])
                                : (st_ff.sck_sync[2] & ~st_ff.sck_sync[3]));
      sck_fall = cs_low & (fast ? (~st_ff.sck_sync[1] & st_ff.sck_sync[2])
                                : (~st_ff.sck_sync[2] & st_ff.sck_sync[3]));
      mosi_bit = fast ? st_ff.mosi_sync[1] : st_ff.mosi_sync[2];
      shift_edge = st_ff.rxlen[`LEN_TX_EDGE] ? sck_rise : sck_fall; // [R7] [R8]
      tx_busy = st_ff.txptr[`TXP_TX_EN] & cs_low; // [R5]
      ring_tx_en = st_ff.rbuf[`RB_TX_EN];
      ring_rx_en = st_ff.rbuf[`RB_RX_EN]; // [R15]

      // ----------------------------------------------------------------------
      // APB: read data captured in setup, zero wait in access
      // ----------------------------------------------------------------------
      sel = reg_sel(paddr);
      wr_acc = psel & penable & pwrite & (sel != 3'd7);
      if (psel & ~penable) begin
         case (sel)
            3'd0: nxt_st.prdata = {16'h0000, st_ff.cfg};
            3'd1: nxt_st.prdata = {16'h0000, st_ff.txptr[15:14], tx_busy, 4'h0, st_ff.txptr[8:0]};
            3'd2: nxt_st.prdata = {16'h0000, st_ff.rxlen[15:14], 4'h0, st_ff.rxlen[9:0]};
            3'd3: nxt_st.prdata = {16'h0000, 2'b00, st_ff.rx_busy, st_ff.rxptr[12], 3'h0, st_ff.rxptr[8:0]}; // [R11]
            3'd4: nxt_st.prdata = {16'h0000, 8'h00, st_ff.rbuf[7:0]};
            3'd5: nxt_st.prdata = {16'h0000, 7'h00, st_ff.rx_addr[8:0]}; // [R14]
            3'd6: nxt_st.prdata = {16'h0000, st_ff.evt};
            default: nxt_st.prdata = 32'h0000_0000;
         endcase
      end
      if (wr_acc) begin
         case (sel)
            3'd0: nxt_st.cfg = {pwdata[15:13], 13'h0000};
            3'd1: nxt_st.txptr = {pwdata[15:14], 5'h00, pwdata[8:0]};
            3'd2: nxt_st.rxlen = {pwdata[15:14], 4'h0, st_ff.rxlen[9:0]};
            3'd3: nxt_st.rxptr = {3'b000, pwdata[12], 3'h0, pwdata[8:0]};
            3'd4: nxt_st.rbuf = {8'h00, pwdata[7:0]};
            3'd6: begin
               nxt_st.evt[`EV_ENABLE] = pwdata[`EV_ENABLE];
               nxt_st.evt = nxt_st.evt & ~(pwdata[15:0] & `EV_W1C_MASK); // [R22]
            end
            default: nxt_st.prdata = st_ff.prdata;
         endcase
      end

      // ----------------------------------------------------------------------
      // Hardware events below win over the software clear above
      // ----------------------------------------------------------------------
      if (cs_fall) begin
         nxt_st.evt[`EV_START] = 1'b1; // [R17] [R4]
         nxt_st.evt[`EV_ABORT] = 1'b0; // [R21]
         nxt_st.rx_bits = 3'd0;
         nxt_st.tx_bits = 3'd0;
         nxt_st.tx_lo = 1'b0;
         nxt_st.rx_half = 1'b0;
         if (st_ff.txptr[`TXP_TX_EN]) begin
            nxt_st.tx_addr = {2'b00, st_ff.txptr[8:0]}; // [R6]
            nxt_st.mem_rd = 1'b1;
            nxt_st.tx_state = TX_LOAD;
            nxt_st.miso_oe = 1'b1;
         end
         if (st_ff.txptr[`TXP_RX_EN]) begin
            nxt_st.rx_busy = 1'b1; // [R11]
            nxt_st.rx_addr = {2'b00, st_ff.rxptr[8:0]}; // [R13] [R14]
            nxt_st.rx_count = 10'd0;
         end
      end

      // ----------------------------------------------------------------------
      // Receive path
      // ----------------------------------------------------------------------
      if (sck_rise) begin
         rx_byte = st_ff.cfg[`CFG_RX_MSB] ? {st_ff.rx_shift[6:0], mosi_bit}
                                          : {mosi_bit, st_ff.rx_shift[7:1]}; // [R3]
         nxt_st.rx_shift = rx_byte;
         nxt_st.rx_bits = st_ff.rx_bits + 3'd1;
         if (st_ff.rx_bits == 3'd7 && st_ff.rx_busy && st_ff.txptr[`TXP_RX_EN]) begin // [R4]
            nxt_st.rx_count = st_ff.rx_count + 10'd1;
            if (st_ff.rx_half) begin
               // First byte of a pair lands in the high half of the word
               nxt_st.mem_wr = 1'b1; // [R23]
               nxt_st.mem_wr_addr = st_ff.rx_addr;
               nxt_st.mem_wr_data = {st_ff.rx_hi, rx_byte};
               adv = ring_next(st_ff.rx_addr, ring_rx_en, st_ff.rbuf[2:0]);
               nxt_st.rx_addr = adv;
               mark = ring_mark(adv, st_ff.rbuf[2:0]);
               if (ring_rx_en) begin
                  nxt_st.evt[`EV_RX_HALF1] = st_ff.evt[`EV_RX_HALF1] | mark[0]; // [R18]
                  nxt_st.evt[`EV_RX_HALF2] = st_ff.evt[`EV_RX_HALF2] | mark[1]; // [R18]
               end
               nxt_st.rx_half = 1'b0;
            end else begin
               nxt_st.rx_hi = rx_byte;
               nxt_st.rx_half = 1'b1;
            end
         end
      end

      // ----------------------------------------------------------------------
      // Transmit path
      // ----------------------------------------------------------------------
      tx_byte = st_ff.tx_lo ? st_ff.tx_word[7:0] : st_ff.tx_word[15:8];
      case (st_ff.tx_state)
         TX_IDLE: begin
            if (!cs_fall) begin
               nxt_st.miso = 1'b0;
               nxt_st.miso_oe = 1'b0;
            end
         end
         TX_LOAD: nxt_st.tx_state = TX_FETCH;
         TX_FETCH: begin
            nxt_st.tx_word = mem_rd_data;
            nxt_st.tx_state = TX_RUN;
         end
         TX_RUN: begin
            nxt_st.miso = st_ff.cfg[`CFG_TX_MSB] ? tx_byte[3'd7 - st_ff.tx_bits] : tx_byte[st_ff.tx_bits]; // [R3]
            if (shift_edge) begin
               nxt_st.tx_bits = st_ff.tx_bits + 3'd1;
               if (st_ff.tx_bits == 3'd7) begin
                  nxt_st.tx_lo = ~st_ff.tx_lo;
                  if (st_ff.tx_lo) begin
                     adv = ring_next(st_ff.tx_addr, ring_tx_en, st_ff.rbuf[6:4]);
                     nxt_st.tx_addr = adv; // [R23]
                     nxt_st.mem_rd = 1'b1;
                     nxt_st.tx_state = TX_LOAD;
                     mark = ring_mark(adv, st_ff.rbuf[6:4]);
                     if (ring_tx_en) begin
                        nxt_st.evt[`EV_TX_HALF1] = st_ff.evt[`EV_TX_HALF1] | mark[0]; // [R18]
                        nxt_st.evt[`EV_TX_HALF2] = st_ff.evt[`EV_TX_HALF2] | mark[1]; // [R18]
                     end
                  end
               end
            end
         end
         default: nxt_st.tx_state = TX_IDLE;
      endcase
      if (!st_ff.txptr[`TXP_TX_EN] && st_ff.tx_state != TX_IDLE) begin
         nxt_st.tx_state = TX_IDLE; // [R4]
      end

      // ----------------------------------------------------------------------
      // End of frame
      // ----------------------------------------------------------------------
      if (cs_rise) begin
         nxt_st.evt[`EV_STOP] = 1'b1; // [R17]
         if (st_ff.rx_bits != 3'd0) begin
            nxt_st.evt[`EV_ABORT] = 1'b1; // [R21]
         end
         if (st_ff.rx_busy) begin
            nxt_st.rx_busy = 1'b0;
            nxt_st.rxlen[9:0] = st_ff.rx_count; // [R10]
            if (st_ff.rx_half) begin
               // Odd trailing byte is stored with a zero low half
               nxt_st.mem_wr = 1'b1;
               nxt_st.mem_wr_addr = st_ff.rx_addr;
               nxt_st.mem_wr_data = {st_ff.rx_hi, 8'h00};
               nxt_st.rx_addr = ring_next(st_ff.rx_addr, ring_rx_en, st_ff.rbuf[2:0]);
               nxt_st.rx_half = 1'b0;
            end
         end
         if (st_ff.tx_state != TX_IDLE) begin
            nxt_st.tx_state = TX_IDLE;
            nxt_st.miso_oe = 1'b0;
            if (st_ff.rxptr[`RXP_AUTO]) begin
               nxt_st.txptr[`TXP_RX_EN] = 1'b1; // [R12]
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.cs_sync <= `SYNC_RESET;
         st_ff.tx_state <= TX_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign prdata = st_ff.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & (reg_sel(paddr) == 3'd7);
   assign spi_miso_out = st_ff.miso;
   assign spi_miso_oe = st_ff.miso_oe;
   assign pin_route_select = st_ff.rxlen[`LEN_PIN_ROUTE]; // [R1]
   assign event_request = st_ff.evt[`EV_ENABLE] & (|(st_ff.evt & (`EV_W1C_MASK | 16'h0200))); // [R20]
   assign mem_rd_en = st_ff.mem_rd;
   assign mem_rd_addr = st_ff.tx_addr;
   assign mem_wr_en = st_ff.mem_wr;
   assign mem_wr_addr = st_ff.mem_wr_addr;
   assign mem_wr_data = st_ff.mem_wr_data;

endmodule
`default_nettype wire

// *** sim/spi_slave_assertions.sv ***
// Port-level assertions for the SPI slave ring buffer
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_cfg.svh"
module spi_slave_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        chip_select_n,
   input wire logic        spi_miso_oe,
   input wire logic        pin_route_select,
   input wire logic        event_request,
   input wire logic        mem_rd_en,
   input wire logic        mem_wr_en
);
   // ----------------------------------------
   // Idle counter and checks
   // ----------------------------------------
   logic [3:0] hi_cnt_ff;
   logic [3:0] nxt_hi_cnt;
   always_comb begin
      nxt_hi_cnt = hi_cnt_ff;
      if (!chip_select_n)
         nxt_hi_cnt = 4'h0;
      else if (hi_cnt_ff != 4'hF)
         nxt_hi_cnt = hi_cnt_ff + 4'h1;
   end
   // Starts saturated so nothing counts as a frame after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         hi_cnt_ff <= 4'hF;
      else
         hi_cnt_ff <= nxt_hi_cnt;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr(idx);
      psel && !penable && pwrite ##1 psel && penable && paddr == {14'h0, idx, 2'b00};
   endsequence
   a_route_follow: assert property (s_wr(`IDX_RX_LENGTH) |=> pin_route_select == $past(pwdata[15]))
      else $error("pin route not taken from write");
   a_event_gate: assert property ((s_wr(`IDX_EVENT_STATUS) ##0 !pwdata[14]) |=> !event_request)
      else $error("event request without enable");
   a_oe_route: assert property (!pin_route_select |-> !spi_miso_oe)
      else $error("miso driven while pins not routed");
   a_oe_idle: assert property (hi_cnt_ff == 4'hF |-> !spi_miso_oe)
      else $error("miso driven while deselected");
   a_mem_quiet: assert property ((mem_rd_en || mem_wr_en) |-> hi_cnt_ff < 4'hC)
      else $error("memory access outside a frame");
   a_wr_pulse: assert property (mem_wr_en |=> !mem_wr_en)
      else $error("memory write longer than a cycle");
   a_rd_space: assert property (mem_rd_en |=> !mem_rd_en [*8])
      else $error("memory reads too close");
   a_err_phase: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   a_err_unal: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("unaligned access not refused");
   a_rd_clean: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000 && (!pslverr || prdata == 32'h0))
      else $error("read data upper half or refused data not zero");
endmodule
bind spi_slave_ring_buffer spi_slave_assertions chk (.*);
`default_nettype wire

// *** sim/spi_master_model.sv ***
// Behavioural SPI master for the slave's link pins
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   output var  logic sck,
   output var  logic cs_n,
   output var  logic mosi,
   input  wire logic miso
);
   // ----------------------------------------
   // Frame and bit tasks
   // ----------------------------------------
   // 160 ns bit period, far under a quarter of the core clock
   localparam int HALF = 80;
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // Odd offset keeps pin edges away from core clock edges
   task automatic frame_start();
      #7;
      cs_n = 1'b0;
      #(2 * HALF);
   endtask
   // Released data line flips so a stale sample cannot pass
   task automatic frame_end();
      #HALF;
      cs_n = 1'b1;
      mosi = ~mosi;
      #(2 * HALF);
   endtask
   // Clock idles low, stands still between frames
   task automatic bit_x(input logic b, output logic r);
      mosi = b;
      #HALF;
      r = miso;
      sck = 1'b1;
      #HALF;
      sck = 1'b0;
   endtask
   task automatic byte_x(input logic [7:0] t, input logic msb, output logic [7:0] r);
      logic q;
      for (int i = 0; i < 8; i++) begin
         bit_x(msb ? t[7 - i] : t[i], q);
         r[msb ? 7 - i : i] = q;
      end
   endtask
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the SPI slave ring buffer
`timescale 1ns/1ps
`default_nettype none
`include "spi_slave_cfg.svh"
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata;
   logic        spi_clk, chip_select_n, spi_mosi, spi_miso_out, spi_miso_oe;
   logic        pin_route_select, event_request, mem_rd_en, mem_wr_en;
   logic [10:0] mem_rd_addr, mem_wr_addr;
   logic [15:0] mem_rd_data, mem_wr_data, r16;
   logic [26:0] wq[$];
   int          mismatches, n_checks;
   wire logic   miso_w;
   // ----------------------------------------
   // Design, far end and memory
   // ----------------------------------------
   // Released miso reads high: the shared line has a pull-up
   assign miso_w = spi_miso_oe ? spi_miso_out : 1'b1;
   spi_slave_ring_buffer uut (.*);
   spi_master_model mdl (.sck(spi_clk), .cs_n(chip_select_n), .mosi(spi_mosi), .miso(miso_w));
   function automatic logic [15:0] pat(input logic [10:0] a);
      return {5'h00, a} ^ 16'h5A3C;
   endfunction
   function automatic logic [10:0] nxt(input logic [10:0] a, input logic rg, input logic [10:0] m);
      return rg ? ((a & ~m) | ((a + 11'h001) & m)) : a + 11'h001;
   endfunction
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // One-cycle read latency; stale data is scrambled
   always @(posedge pclk) begin
      mem_rd_data <= mem_rd_en ? pat(mem_rd_addr) : ~mem_rd_data;
      if (mem_wr_en === 1'b1)
         wq.push_back({mem_wr_addr, mem_wr_data});
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [15:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
         @(posedge pclk);
      while (pready !== 1'b1 && ++k < 64);
      if (k >= 64)
         mismatches++;
      r16 = prdata[15:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] idx, input logic [15:0] d);
      apb(1'b1, {14'h0, idx, 2'b00}, d);
   endtask
   task automatic rdc(input logic [15:0] idx, input logic [15:0] e, input logic [15:0] m);
      apb(1'b0, {14'h0, idx, 2'b00}, 16'h0000);
      chk({16'h0000, r16 & m}, {16'h0000, e});
   endtask
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #300us;
      mismatches++;
      end_of_test();
   end
   initial begin
      logic [7:0]  b[6];
      logic [7:0]  r0, r1;
      logic [8:0]  st;
      logic [10:0] a, msk;
      logic [15:0] v;
      logic        msb, rg;
      logic [1:0]  sz;
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      mem_rd_data = 16'h0000;
      void'($urandom(52654));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 7; i++)
         rdc(16'(`IDX_SLAVE_CONFIG + i), 16'h0000, 16'hFFFF);
      apb(1'b0, 32'h0003F19C, 16'h0000);
      chk({15'h0, err, r16}, 32'h10000);
      apb(1'b0, 32'h0003F182, 16'h0000);
      chk({15'h0, err, r16}, 32'h10000);
      wr(`IDX_RX_CURRENT, 16'hFFFF);
      rdc(`IDX_RX_CURRENT, 16'h0000, 16'hFFFF);
      v = 16'($urandom);
      wr(`IDX_SLAVE_CONFIG, v);
      rdc(`IDX_SLAVE_CONFIG, v & 16'hE000, 16'hE000);
      wr(`IDX_RING_CONFIG, v);
      rdc(`IDX_RING_CONFIG, v & 16'h00FF, 16'h00FF);
      wr(`IDX_RX_LENGTH, 16'h8000);
      @(negedge pclk);
      chk({31'h0, pin_route_select}, 32'h1);
      // Ring runs start two words short of the end so the pointer wraps
      for (int it = 0; it < 4; it++) begin
         rg = it[0];
         sz = 2'($urandom_range(3));
         msb = 1'($urandom_range(1));
         msk = (11'h040 << sz) - 11'h001;
         st = 9'($urandom_range(511));
         if (rg)
            st = (st & ~msk[8:0]) | (msk[8:0] - 9'h001);
         wr(`IDX_SLAVE_CONFIG, {1'b0, msb, 14'h0});
         wr(`IDX_RING_CONFIG, {12'h0, rg, 1'b0, sz});
         wr(`IDX_RX_POINTER, {7'h0, st});
         wr(`IDX_TX_POINTER, 16'h4000);
         wr(`IDX_EVENT_STATUS, 16'h3C0C);
         mdl.frame_start();
         rdc(`IDX_RX_POINTER, 16'h2000, 16'h2000);
         rdc(`IDX_RX_CURRENT, {7'h0, st}, 16'h01FF);
         for (int k = 0; k < 5; k++) begin
            b[k] = 8'($urandom);
            mdl.byte_x(b[k], msb, r0);
         end
         mdl.frame_end();
         chk(32'(wq.size()), 32'd3);
         a = {2'b00, st};
         for (int k = 0; k < 3; k++) begin
            v = {b[2 * k], (k < 2) ? b[2 * k + 1] : 8'h00};
            chk({5'h00, wq.pop_front()}, {5'h00, a, v});
            a = nxt(a, rg, msk);
         end
         rdc(`IDX_RX_LENGTH, 16'h0005, 16'h03FF);
         rdc(`IDX_EVENT_STATUS, {4'h0, rg, 7'h0, 4'hC}, 16'h080C);
         rdc(`IDX_RX_POINTER, 16'h0000, 16'h2000);
      end
      for (int e = 0; e < 2; e++) begin
         msb = 1'($urandom_range(1));
         st = 9'($urandom_range(511));
         wr(`IDX_RX_LENGTH, {1'b1, e[0], 14'h0});
         wr(`IDX_SLAVE_CONFIG, {e[0], 1'b0, msb, 13'h0});
         wr(`IDX_RING_CONFIG, 16'h0000);
         wr(`IDX_RX_POINTER, 16'h1000);
         wr(`IDX_TX_POINTER, {7'h00, st});
         wr(`IDX_TX_POINTER, {7'h40, st});
         mdl.frame_start();
         rdc(`IDX_TX_POINTER, 16'h2000, 16'h2000);
         mdl.byte_x(8'($urandom), msb, r0);
         mdl.byte_x(8'($urandom), msb, r1);
         mdl.frame_end();
         chk({16'h0, r0, r1}, {16'h0, pat({2'b00, st})});
         rdc(`IDX_TX_POINTER, 16'h4000, 16'h6000);
         chk(32'(wq.size()), 32'd0);
      end
      // Half a byte, then deselect: the abort flag must show
      wr(`IDX_TX_POINTER, 16'h0000);
      wr(`IDX_EVENT_STATUS, 16'h3C0C);
      mdl.frame_start();
      repeat (4) mdl.bit_x(1'b1, r0[0]);
      mdl.frame_end();
      rdc(`IDX_EVENT_STATUS, 16'h020C, 16'h7E0C);
      chk({31'h0, event_request}, 32'h0);
      wr(`IDX_EVENT_STATUS, 16'h400C);
      rdc(`IDX_EVENT_STATUS, 16'h4200, 16'h7E0C);
      chk({31'h0, event_request}, 32'h1);
      mdl.frame_start();
      rdc(`IDX_EVENT_STATUS, 16'h0000, 16'h0200);
      mdl.frame_end();
      end_of_test();
   end
endmodule
`default_nettype wire
